// ==== hdl/lsrt_defs.svh ====
`ifndef LSRT_DEFS_SVH
`define LSRT_DEFS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LSRT_CLK_MHZ      100
`define LSRT_TICK_US      2000
`define LSRT_TICK_CYC     (`LSRT_TICK_US * `LSRT_CLK_MHZ)
`define LSRT_TICK_W       18

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LSRT_OFS_IRQ_CLR  8'h00
`define LSRT_OFS_TRIP_CFG 8'h04
`define LSRT_OFS_DEB_STAT 8'h08
`define LSRT_OFS_BD_A     8'h0C
`define LSRT_OFS_BD_B     8'h10
`define LSRT_OFS_BD_C     8'h14
`define LSRT_OFS_DEB_CFG  8'h18
`define LSRT_LOCAL_BASE   3'h1
`define LSRT_NUM_SRC      5

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define LSRT_LS_SO_A      5
`define LSRT_LS_SO_B      6
`define LSRT_LS_PEND_LSB  8
`define LSRT_BD_LVL_LSB   4
`define LSRT_DEB_B_LSB    5
`define LSRT_TRIP_RST     7'h00
`define LSRT_DEB_CFG_RST  10'h0C6
`endif

// ==== hdl/lsrt_pkg.sv ====
package lsrt_pkg;

  // ring trip configuration word, low bits of its register
  typedef struct packed {
    logic       out_pol;
    logic       in_pol;
    logic [2:0] out_sel;
    logic       in_sel;
    logic       enable;
  } lsrt_trip_cfg_t;

  // trip output select codes
  typedef enum logic [2:0] {
    LSRT_SEL_OUT_A = 3'h0,
    LSRT_SEL_OUT_B = 3'h1,
    LSRT_SEL_BD_A  = 3'h2,
    LSRT_SEL_BD_B  = 3'h3,
    LSRT_SEL_BD_C  = 3'h4
  } lsrt_out_sel_t;

endpackage

// ==== hdl/lsrt_top.sv ====
`timescale 1ns/1ps
`include "lsrt_defs.svh"

module lsrt_top #(
  parameter int TICK_CYC = `LSRT_TICK_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic [3:0]  line_input_a_in,
  input  wire logic [3:0]  line_input_b_in,
  input  wire logic [3:0]  bidir_pin_a_in,
  output logic [3:0]       bidir_pin_a_out,
  output logic [3:0]       bidir_pin_a_oe_out,
  input  wire logic [3:0]  bidir_pin_b_in,
  output logic [3:0]       bidir_pin_b_out,
  output logic [3:0]       bidir_pin_b_oe_out,
  input  wire logic [3:0]  bidir_pin_c_in,
  output logic [3:0]       bidir_pin_c_out,
  output logic [3:0]       bidir_pin_c_oe_out,
  output logic [3:0]       line_output_a_out,
  output logic [3:0]       line_output_b_out,
  output logic             irq_out_low_pair_out,
  output logic             irq_out_low_pair_oe_out,
  output logic             irq_out_high_pair_out,
  output logic             irq_out_high_pair_oe_out
);

  localparam logic [`LSRT_TICK_W-1:0] TICK_LAST =
    `LSRT_TICK_W'(TICK_CYC - 1);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic local_hit(input logic [7:0] a);
    local_hit = (a[7:5] == `LSRT_LOCAL_BASE);
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] a);
    chan_of = a[4:3];
  endfunction

  function automatic logic [1:0] bd_of(input logic [7:0] a);
    bd_of = 2'((a - `LSRT_OFS_BD_A) >> 2);
  endfunction

  function automatic logic bd_hit(input logic [7:0] a);
    bd_hit = (a == `LSRT_OFS_BD_A) || (a == `LSRT_OFS_BD_B) ||
             (a == `LSRT_OFS_BD_C);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0]                 la_s1_reg;
  logic [3:0]                 lb_s1_reg;
  logic [1:0][3:0]            in_s2_reg;
  logic [2:0][3:0]            bd_s1_reg;
  logic [2:0][3:0]            bd_s2_reg;
  logic [`LSRT_TICK_W-1:0]    tick_cnt_reg;
  logic                       tick_reg;
  logic [1:0][3:0][4:0]       cnt_reg;
  logic [1:0][3:0]            deb_reg;
  logic [3:0][4:0]            src_prev_reg;
  logic [3:0][4:0]            pend_reg;
  logic [3:0][4:0]            pend_next;
  logic [3:0][4:0]            new_evt;
  logic [3:0][4:0]            src_now;
  logic [3:0][4:0]            in_mask;
  lsrt_pkg::lsrt_trip_cfg_t   trip_cfg_reg;
  logic [9:0]                 deb_cfg_reg;
  logic [2:0][3:0]            dir_reg;
  logic [2:0][3:0]            bdo_reg;
  logic [1:0][3:0]            so_reg;
  logic [3:0][4:0]            ie_reg;
  logic [3:0]                 offhook_prev_reg;
  logic [3:0]                 offhook;
  logic [3:0]                 trip_evt;
  logic [3:0]                 trip_reg;
  logic [3:0]                 sw_touch;
  logic [3:0][4:0]            base_lvl;
  logic [3:0][4:0]            out_lvl;
  logic                       wr_pend_reg;
  logic [7:0]                 wr_addr_reg;
  logic [31:0]                hrdata_reg;
  logic [31:0]                rd_mux;
  logic                       irq_lo_reg;
  logic                       irq_hi_reg;
  logic                       acc;
  logic                       rd_acc;
  logic [7:0]                 aa;
  logic                       wr_clr_all;
  logic                       rd_deb;
  logic [2:0]                 rd_bd;
  logic [3:0]                 rd_ls;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // two-stage sampling
  // bidir pins are not debounced, so metastability matters most here
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      la_s1_reg <= 4'h0;
      lb_s1_reg <= 4'h0;
      in_s2_reg <= 8'h00;
      bd_s1_reg <= 12'h000;
      bd_s2_reg <= 12'h000;
    end else begin
      la_s1_reg <= line_input_a_in;
      lb_s1_reg <= line_input_b_in;
      in_s2_reg <= {lb_s1_reg, la_s1_reg};
      bd_s1_reg <= {bidir_pin_c_in, bidir_pin_b_in, bidir_pin_a_in};
      bd_s2_reg <= bd_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // debounce
  // ---------------------------------------------------------------
  // sample tick, one cycle every TICK_CYC
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == TICK_LAST);
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 :
                      tick_cnt_reg + `LSRT_TICK_W'(1);
    end
  end

  // stable-count filter
  // any return to the held level restarts the count
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      deb_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        for (int c = 0; c < 4; c++) begin
          if (in_s2_reg[i][c] == deb_reg[i][c]) begin
            cnt_reg[i][c] <= 5'h00;
          end else if (tick_reg) begin
            if (cnt_reg[i][c] >= deb_cfg_reg[i*5 +: 5]) begin
              deb_reg[i][c] <= in_s2_reg[i][c];
              cnt_reg[i][c] <= 5'h00;
            end else begin
              cnt_reg[i][c] <= cnt_reg[i][c] + 5'h01;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // zero wait state; every transfer answers OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_reg;
  assign acc    = hsel_in && htrans_in[1] && hready_in;
  assign rd_acc = acc && !hwrite_in;
  assign aa     = haddr_in[7:0];

  // side-effect strobes, reads at address phase, clear in data phase
  always_comb begin
    wr_clr_all = wr_pend_reg && (wr_addr_reg == `LSRT_OFS_IRQ_CLR);
    rd_deb     = rd_acc && (aa == `LSRT_OFS_DEB_STAT);
    rd_bd      = 3'h0;
    rd_ls      = 4'h0;
    if (rd_acc && bd_hit(aa)) begin
      rd_bd[bd_of(aa)] = 1'b1;
    end
    if (rd_acc && local_hit(aa) && aa[2]) begin
      rd_ls[chan_of(aa)] = 1'b1;
    end
  end

  // read data selection; upper address bits alias, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aa == `LSRT_OFS_TRIP_CFG) begin
      rd_mux[6:0] = trip_cfg_reg;
    end else if (aa == `LSRT_OFS_DEB_STAT) begin
      // debounced input a low nibble, b high nibble
      rd_mux[7:0] = {deb_reg[1], deb_reg[0]};
    end else if (aa == `LSRT_OFS_DEB_CFG) begin
      rd_mux[9:0] = deb_cfg_reg;
    end else if (bd_hit(aa)) begin
      // inputs show the pin, outputs the driven value
      rd_mux[3:0] = dir_reg[bd_of(aa)];
      rd_mux[`LSRT_BD_LVL_LSB +: 4] =
        (dir_reg[bd_of(aa)] & bdo_reg[bd_of(aa)]) |
        (~dir_reg[bd_of(aa)] & bd_s2_reg[bd_of(aa)]);
    end else if (local_hit(aa) && !aa[2]) begin
      rd_mux[4:0] = ie_reg[chan_of(aa)];
    end else if (local_hit(aa)) begin
      // both dedicated inputs of this channel
      rd_mux[0] = deb_reg[0][chan_of(aa)];
      rd_mux[1] = deb_reg[1][chan_of(aa)];
      for (int p = 0; p < 3; p++) begin
        rd_mux[2 + p] = dir_reg[p][chan_of(aa)] ?
                        bdo_reg[p][chan_of(aa)] :
                        bd_s2_reg[p][chan_of(aa)];
      end
      rd_mux[`LSRT_LS_SO_A] = so_reg[0][chan_of(aa)];
      rd_mux[`LSRT_LS_SO_B] = so_reg[1][chan_of(aa)];
      rd_mux[`LSRT_LS_PEND_LSB +: 5] = pend_reg[chan_of(aa)];
    end
  end

  // address phase capture and registered read data
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= acc && hwrite_in;
      wr_addr_reg <= aa;
      if (rd_acc) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trip_cfg_reg <= `LSRT_TRIP_RST;
      deb_cfg_reg  <= `LSRT_DEB_CFG_RST;
      dir_reg      <= 12'h000;
      bdo_reg      <= 12'h000;
      so_reg       <= 8'h00;
      ie_reg       <= '0;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == `LSRT_OFS_TRIP_CFG) begin
        // enable, input select, output select, polarities
        trip_cfg_reg <= hwdata_in[6:0];
      end
      if (wr_addr_reg == `LSRT_OFS_DEB_CFG) begin
        deb_cfg_reg <= hwdata_in[9:0];
      end
      if (bd_hit(wr_addr_reg)) begin
        // direction bits, output levels only here
        dir_reg[bd_of(wr_addr_reg)] <= hwdata_in[3:0];
        bdo_reg[bd_of(wr_addr_reg)] <= hwdata_in[`LSRT_BD_LVL_LSB +: 4];
      end
      if (local_hit(wr_addr_reg) && !wr_addr_reg[2]) begin
        ie_reg[chan_of(wr_addr_reg)] <= hwdata_in[4:0];
      end
      if (local_hit(wr_addr_reg) && wr_addr_reg[2]) begin
        so_reg[0][chan_of(wr_addr_reg)] <= hwdata_in[`LSRT_LS_SO_A];
        so_reg[1][chan_of(wr_addr_reg)] <= hwdata_in[`LSRT_LS_SO_B];
      end
    end
  end

  // ---------------------------------------------------------------
  // change events and pending flags
  // ---------------------------------------------------------------
  // changes of input-role sources only
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      src_now[c] = {bd_s2_reg[2][c], bd_s2_reg[1][c], bd_s2_reg[0][c],
                    deb_reg[1][c], deb_reg[0][c]};
      in_mask[c] = {~dir_reg[2][c], ~dir_reg[1][c], ~dir_reg[0][c],
                    2'b11};
      new_evt[c] = (src_now[c] ^ src_prev_reg[c]) & in_mask[c] &
                   ie_reg[c];
    end
  end

  // clears from reads and writes, a new event in the same cycle wins
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      pend_next[c] = pend_reg[c];
      if (wr_clr_all) begin
        pend_next[c] = 5'h00;
      end
      // dedicated input sources of every channel
      if (rd_deb) begin
        pend_next[c][1:0] = 2'b00;
      end
      for (int p = 0; p < 3; p++) begin
        if (rd_bd[p]) begin
          pend_next[c][2 + p] = 1'b0;
        end
      end
      if (rd_ls[c]) begin
        pend_next[c] = 5'h00;
      end
      pend_next[c] = pend_next[c] | new_evt[c];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_prev_reg <= '0;
      pend_reg     <= '0;
    end else begin
      src_prev_reg <= src_now;
      pend_reg     <= pend_next;
    end
  end

  // open drain: pin released means asserted high
  // held while anything pending in the pair
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_lo_reg <= 1'b0;
      irq_hi_reg <= 1'b0;
    end else begin
      irq_lo_reg <= |{pend_next[1], pend_next[0]};
      irq_hi_reg <= |{pend_next[3], pend_next[2]};
    end
  end
  assign irq_out_low_pair_out     = 1'b0;
  assign irq_out_low_pair_oe_out  = !irq_lo_reg;
  assign irq_out_high_pair_out    = 1'b0;
  assign irq_out_high_pair_oe_out = !irq_hi_reg;

  // ---------------------------------------------------------------
  // hardware ring trip
  // ---------------------------------------------------------------
  // off-hook level per polarity
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      offhook[c] = (trip_cfg_reg.in_sel ? deb_reg[1][c] : deb_reg[0][c])
                   == trip_cfg_reg.in_pol;
      base_lvl[c] = {bdo_reg[2][c], bdo_reg[1][c], bdo_reg[0][c],
                     so_reg[1][c], so_reg[0][c]};
      // fire only while the output sits at ringing level
      trip_evt[c] = trip_cfg_reg.enable && offhook[c] &&
                    !offhook_prev_reg[c] &&
                    (trip_cfg_reg.out_sel <= lsrt_pkg::LSRT_SEL_BD_C) &&
                    (base_lvl[c][trip_cfg_reg.out_sel] ==
                     trip_cfg_reg.out_pol);
      // software rewriting control ends the override
      sw_touch[c] = wr_pend_reg &&
                    ((local_hit(wr_addr_reg) && wr_addr_reg[2] &&
                      chan_of(wr_addr_reg) == 2'(c)) ||
                     bd_hit(wr_addr_reg) ||
                     wr_addr_reg == `LSRT_OFS_TRIP_CFG);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      offhook_prev_reg <= 4'h0;
      trip_reg         <= 4'h0;
    end else begin
      offhook_prev_reg <= offhook;
      for (int c = 0; c < 4; c++) begin
        if (trip_evt[c]) begin
          trip_reg[c] <= 1'b1;
        end else if (!trip_cfg_reg.enable || sw_touch[c]) begin
          trip_reg[c] <= 1'b0;
        end
      end
    end
  end

  // tripped output goes to its rest level, the inverse of ringing
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < `LSRT_NUM_SRC; k++) begin
        out_lvl[c][k] = (trip_reg[c] && trip_cfg_reg.out_sel == 3'(k)) ?
                        !trip_cfg_reg.out_pol : base_lvl[c][k];
      end
    end
  end

  // registered pin drive for all five output pins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_output_a_out <= 4'h0;
      line_output_b_out <= 4'h0;
      bidir_pin_a_out   <= 4'h0;
      bidir_pin_b_out   <= 4'h0;
      bidir_pin_c_out   <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        line_output_a_out[c] <= out_lvl[c][0];
        line_output_b_out[c] <= out_lvl[c][1];
        bidir_pin_a_out[c]   <= out_lvl[c][2];
        bidir_pin_b_out[c]   <= out_lvl[c][3];
        bidir_pin_c_out[c]   <= out_lvl[c][4];
      end
    end
  end
  assign bidir_pin_a_oe_out = dir_reg[0];
  assign bidir_pin_b_oe_out = dir_reg[1];
  assign bidir_pin_c_oe_out = dir_reg[2];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_trip_cause;
    trip_cfg_reg.enable && trip_evt[0];
  endsequence
  sequence s_trip_drive;
    trip_reg[0] ##1 (out_lvl[0][trip_cfg_reg.out_sel] ==
                     !trip_cfg_reg.out_pol);
  endsequence

  a_trip_fires: assert property (
    s_trip_cause |=> s_trip_drive)
    else $error("ring trip did not override output");

  a_trip_enable: assert property (
    !trip_cfg_reg.enable |=> !trip_reg[0])
    else $error("trip active while disabled");

  a_deb_tick: assert property (
    (deb_reg[0][0] != $past(deb_reg[0][0])) |->
      $past(tick_reg) && $past(cnt_reg[0][0]) >= $past(deb_cfg_reg[4:0]))
    else $error("debounced bit changed early");

  a_clr_all: assert property (
    wr_clr_all |=> ((pend_reg & ~$past(new_evt)) == '0))
    else $error("interrupt clear left bits");

  a_ls_clear: assert property (
    rd_ls[0] |=> (pend_reg[0] == $past(new_evt[0])))
    else $error("line status read did not clear");

  a_ie_gate: assert property (
    (!ie_reg[1][0] && $changed(deb_reg[0][1])) |=> !$rose(pend_reg[1][0]))
    else $error("disabled source became pending");

  a_irq_pair: assert property (
    (|{pend_reg[1], pend_reg[0]}) |-> !irq_out_low_pair_oe_out)
    else $error("low pair irq not asserted");

  a_dir_write: assert property (
    (wr_pend_reg && wr_addr_reg == `LSRT_OFS_BD_A) |=>
      bidir_pin_a_oe_out == $past(hwdata_in[3:0]))
    else $error("direction write not applied");

  a_so_write: assert property (
    (wr_pend_reg && local_hit(wr_addr_reg) && wr_addr_reg[2] &&
     chan_of(wr_addr_reg) == 2'h0) |=>
      so_reg[0][0] == $past(hwdata_in[`LSRT_LS_SO_A]))
    else $error("output bit not stored");

endmodule

// ==== dv/lsrt_slic_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// line card model: hook inputs and bidir wires
// ---------------------------------------------
module lsrt_slic_model (
  input  wire logic        clk_in,
  input  wire logic [3:0]  hook_a_in,
  input  wire logic [3:0]  hook_b_in,
  input  wire logic [11:0] bd_drive_in,
  input  wire logic [11:0] bd_out_in,
  input  wire logic [11:0] bd_oe_in,
  output logic [3:0]       line_a_out,
  output logic [3:0]       line_b_out,
  output logic [11:0]      bd_wire_out
);
  // line card answers a clock late, never in the same edge
  always_ff @(posedge clk_in) begin
    line_a_out <= hook_a_in;
    line_b_out <= hook_b_in;
  end
  // device wins where it drives, line card elsewhere
  assign bd_wire_out = (bd_oe_in & bd_out_in) | (~bd_oe_in & bd_drive_in);
endmodule

// ==== dv/line_signaling_ring_trip_test.sv ====
`timescale 1ns/1ps
module line_signaling_ring_trip_test;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, lo_oe, hi_oe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [3:0]  hook_a, hook_b, line_a, line_b, out_a, out_b, t;
  logic [11:0] bd_drive, bd_out, bd_oe, bd_wire;
  int          err_total, n_compared, cyc_n, seed, c, k;

  lsrt_top #(.TICK_CYC(4)) dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata),
    .line_input_a_in(line_a), .line_input_b_in(line_b),
    .bidir_pin_a_in(bd_wire[3:0]), .bidir_pin_a_out(bd_out[3:0]),
    .bidir_pin_a_oe_out(bd_oe[3:0]), .bidir_pin_b_in(bd_wire[7:4]),
    .bidir_pin_b_out(bd_out[7:4]), .bidir_pin_b_oe_out(bd_oe[7:4]),
    .bidir_pin_c_in(bd_wire[11:8]), .bidir_pin_c_out(bd_out[11:8]),
    .bidir_pin_c_oe_out(bd_oe[11:8]), .line_output_a_out(out_a),
    .line_output_b_out(out_b), .irq_out_low_pair_out(),
    .irq_out_low_pair_oe_out(lo_oe), .irq_out_high_pair_out(),
    .irq_out_high_pair_oe_out(hi_oe));

  lsrt_slic_model slic (
    .clk_in(clk), .hook_a_in(hook_a), .hook_b_in(hook_b),
    .bd_drive_in(bd_drive), .bd_out_in(bd_out), .bd_oe_in(bd_oe),
    .line_a_out(line_a), .line_b_out(line_b), .bd_wire_out(bd_wire));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  always #5 clk = ~clk;

  // one single-word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // settle one step past the edge so registered outputs have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // readback of a bidir control: stored level if driving, pin if not
  function automatic logic [7:0] bd_exp(logic [3:0] d, logic [3:0] l,
                                        logic [3:0] p);
    return {(d & l) | (~d & p), d};
  endfunction

  // a trip flips the ringing level back to rest only when enabled
  function automatic logic trip_exp(logic en, logic op);
    return en ? ~op : op;
  endfunction

  // hang guard, well above the roughly nine hundred cycles the run needs
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      results;
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {clk, rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {hook_a, hook_b, bd_drive, err_total, n_compared} = '0;
    hsize = 3'h2;
    seed = 71793;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd, 32'hC6);
    chk({hresp, lo_oe, hi_oe}, 3'b011);
    bus(1'b1, 8'h18, 32'h21);
    for (c = 0; c < 4; c++) begin
      v = $random(seed);
      bus(1'b1, 8'h20 + 8'(8 * c), 32'h1F);
      bus(1'b1, 8'h24 + 8'(8 * c), v & 32'h60);
      wt(2);
      chk({out_b[c], out_a[c]}, v[6:5]);
      bus(1'b0, 8'h24 + 8'(8 * c), 32'h0);
      chk(rd[6:5], v[6:5]);
    end
    for (c = 0; c < 3; c++) begin
      v = $random(seed);
      bd_drive[4*c+:4] <= 4'($random(seed));
      bus(1'b1, 8'h0C + 8'(4 * c), {24'h000000, v[7:0]});
      wt(4);
      bus(1'b0, 8'h0C + 8'(4 * c), 32'h0);
      chk(rd[7:0], bd_exp(v[3:0], v[7:4], bd_drive[4*c+:4]));
      chk({bd_oe[4*c+:4], bd_out[4*c+:4] & v[3:0]},
          {v[3:0], v[3:0] & v[7:4]});
    end
    // debounced inputs and their interrupts
    hook_a[2] <= 1'b1;
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    wt(60);
    chk({lo_oe, hi_oe}, 2'b10);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h04);
    wt(2);
    chk({lo_oe, hi_oe}, 2'b11);
    hook_b[0] <= 1'b1;
    wt(60);
    bus(1'b0, 8'h24, 32'h0);
    chk({rd[12:8], rd[1:0]}, 7'h0A);
    wt(2);
    chk({lo_oe, hi_oe}, 2'b11);
    bus(1'b1, 8'h28, 32'h0);
    hook_a[1] <= 1'b1;
    wt(60);
    chk({lo_oe, hi_oe}, 2'b11);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h16);
    // bidir input events
    bus(1'b1, 8'h0C, 32'h0);
    wt(6);
    bus(1'b1, 8'h00, 32'h0);
    bd_drive[0] <= ~bd_drive[0];
    bd_drive[3] <= ~bd_drive[3];
    wt(6);
    chk({lo_oe, hi_oe}, 2'b00);
    bus(1'b0, 8'h10, 32'h0);
    wt(2);
    chk({lo_oe, hi_oe}, 2'b00);
    bus(1'b0, 8'h0C, 32'h0);
    wt(2);
    chk({lo_oe, hi_oe}, 2'b11);
    bd_drive[3] <= ~bd_drive[3];
    wt(6);
    chk({lo_oe, hi_oe}, 2'b10);
    bus(1'b1, 8'h00, 32'h5A);
    wt(2);
    chk({lo_oe, hi_oe}, 2'b11);
    // ring trip: rows are enable, input select, in and out polarity;
    // odd rows trip dedicated output b, even rows output a
    for (k = 0; k < 4; k++) begin
      t = (k == 0) ? 4'h1 : (k == 1) ? 4'h9 : (k == 2) ? 4'hF : 4'hA;
      if (t[2]) hook_b[0] <= ~t[1];
      else hook_a[0] <= ~t[1];
      wt(60);
      v = 32'({t[0], 5'h00}) << k[0];
      bus(1'b1, 8'h24, v);
      bus(1'b1, 8'h04, 32'({t[0], t[1], 2'h0, k[0], t[2], t[3]}));
      wt(2);
      chk(k[0] ? out_b[0] : out_a[0], t[0]);
      if (t[2]) hook_b[0] <= t[1];
      else hook_a[0] <= t[1];
      wt(60);
      chk(k[0] ? out_b[0] : out_a[0], trip_exp(t[3], t[0]));
      bus(1'b0, 8'h24, 32'h0);
      chk(rd[5 + k[0]], t[0]);
      v = 32'({trip_exp(t[3], t[0]), 5'h00}) << k[0];
      bus(1'b1, 8'h24, v);
      wt(2);
      chk(k[0] ? out_b[0] : out_a[0], trip_exp(t[3], t[0]));
    end
    results;
  end
endmodule
